// *** common/opctl_defines.svh ***
`ifndef OPCTL_DEFINES_SVH
`define OPCTL_DEFINES_SVH

// Register byte offsets
`define OFF_CONTROL 12'h000
`define OFF_CMP_ADDR 12'h004
`define OFF_COMMAND 12'h008
`define OFF_STATUS 12'h00c
`define OFF_STOP_ADDR 12'h010
`define OFF_STOP_HALF 12'h014
`define OFF_DISP_ADDR 12'h018
`define OFF_PAGE_DESC 12'h01c
`define OFF_EVENTS 12'h020

// Control fields
`define CTL_CMP_ARM 0
`define CTL_CMP_CLASS_LO 1
`define CTL_HARD_STOP 3
`define CTL_TIMER_ON 4
`define CTL_SINGLE_STEP 5
`define CTL_VIRT_MODE 6
`define CTL_INLINE_TEST 7

// Command bits (write one to act)
`define CMD_START 0
`define CMD_STOP 1
`define CMD_PAGE_UP 2
`define CMD_PAGE_DOWN 3
`define CMD_TOD_ENABLE 4
`define CMD_IPL_START 5
`define CMD_SAVE_START 6

// Page description alterable mask: addressable, connected, disconnected
`define PD_ALTER_MASK 16'h0007
`define PAGE_BYTES 24'h000040
`define ADDR_MASK 24'hffffff

// Timing
`define CLK_MHZ 125
`define TOD_ENABLE_MS 2000
`define TOD_ENABLE_CYCLES (`TOD_ENABLE_MS * 1000 * `CLK_MHZ)

`endif

// *** common/opctl_pkg.sv ***
`default_nettype none
package opctl_pkg;
  typedef enum logic [1:0] {
    CMP_ANY = 2'b00,
    CMP_IFETCH = 2'b01,
    CMP_STORE = 2'b10,
    CMP_IO = 2'b11
  } cmp_class_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_MANUAL = 3'b001,
    ST_HALTED_ON_ERROR_INDICATOR = 3'b010,
    ST_LOAD_FAIL = 3'b011,
    ST_TEST = 3'b100
  } proc_ind_t;

  typedef enum logic [1:0] {
    RUN_GO = 2'b00,
    RUN_STOPPED = 2'b01,
    RUN_HALTED_ON_ERROR_INDICATOR = 2'b10
  } run_state_t;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic is_ifetch;
    logic is_store;
    logic is_io;
  } access_t;

  typedef struct packed {
    logic boundary;
    logic [23:0] next_addr;
    logic [15:0] next_half;
  } insn_t;

  typedef struct packed {
    logic machine_check;
    logic channel_check;
    logic mc_enabled;
  } check_t;
endpackage
`default_nettype wire

// *** hw/opctl.sv ***
`include "opctl_defines.svh"
`default_nettype none
module opctl
  import opctl_pkg::*;
#(
  parameter int unsigned TOD_CYCLES = `TOD_ENABLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Processor observation
  input wire access_t access_in,
  input wire insn_t insn_in,
  input wire check_t check_in,
  input wire logic ipl_done,
  input wire logic ipl_failed,
  input wire logic save_done,
  input wire logic save_abort,
  // Processor control
  output logic proc_run,
  output logic timer_enable,
  output logic mc_interrupt,
  output logic mc_logout,
  output logic tod_set_allowed,
  output logic single_step_mode
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] ctl_r;
  logic [23:0] cmp_addr_r;
  logic [23:0] stop_addr_r;
  logic [15:0] stop_half_r;
  logic [23:0] disp_addr_r;
  logic [15:0] page_desc_r;
  logic cmp_hit_r;
  logic saved_r;
  logic loading_r;
  logic load_fail_r;
  logic tod_open_r;
  logic [31:0] tod_cnt_r;
  logic step_armed_r;
  run_state_t run_r;
  proc_ind_t ind_r;

  wire addr_ok = hsel && hready && htrans[1];
  wire wr_now = wr_pend_r;
  wire ctl_wr = wr_now && (wr_addr_r == `OFF_CONTROL);
  wire cmd_wr = wr_now && (wr_addr_r == `OFF_COMMAND);
  wire cmd_start = cmd_wr && hwdata[`CMD_START];
  wire cmd_stop = cmd_wr && hwdata[`CMD_STOP];
  wire cmd_pgup = cmd_wr && hwdata[`CMD_PAGE_UP];
  wire cmd_pgdn = cmd_wr && hwdata[`CMD_PAGE_DOWN];
  wire cmd_tod = cmd_wr && hwdata[`CMD_TOD_ENABLE];
  wire cmd_ipl = cmd_wr && hwdata[`CMD_IPL_START];
  wire disp_wr = wr_now && (wr_addr_r == `OFF_DISP_ADDR);
  wire pd_wr = wr_now && (wr_addr_r == `OFF_PAGE_DESC);
  wire arm = ctl_r[`CTL_CMP_ARM];
  wire hard = ctl_r[`CTL_HARD_STOP];
  wire step = ctl_r[`CTL_SINGLE_STEP];
  wire [1:0] cls_bits = ctl_r[`CTL_CMP_CLASS_LO +: 2];
  wire stopped = (run_r != RUN_GO);

  function automatic logic class_match(input logic [1:0] c, input access_t a);
    case (c)
      CMP_IFETCH: class_match = a.is_ifetch;
      CMP_STORE: class_match = a.is_store;
      CMP_IO: class_match = a.is_io;
      default: class_match = 1'b1;
    endcase
  endfunction

  wire match = arm && access_in.valid && (access_in.addr == cmp_addr_r) &&
    class_match(cls_bits, access_in);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_r <= haddr[11:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[11:0])
        `OFF_CONTROL: hrdata <= ctl_r;
        `OFF_CMP_ADDR: hrdata <= {8'h00, cmp_addr_r};
        `OFF_STATUS: hrdata <= {19'h00000, ind_r, arm, hard, timer_enable,
          tod_open_r, !tod_open_r, saved_r, loading_r, step, cmp_hit_r, stopped};
        `OFF_STOP_ADDR: hrdata <= {8'h00, stop_addr_r};
        `OFF_STOP_HALF: hrdata <= {16'h0000, stop_half_r};
        `OFF_DISP_ADDR: hrdata <= {8'h00, disp_addr_r};
        `OFF_PAGE_DESC: hrdata <= {16'h0000, page_desc_r};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= 32'h00000000;
      cmp_addr_r <= 24'h000000;
    end else begin
      if (ctl_wr) begin
        ctl_r <= {24'h000000, hwdata[7:0]};
      end
      if (wr_now && (wr_addr_r == `OFF_CMP_ADDR)) begin
        cmp_addr_r <= hwdata[23:0] & `ADDR_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  wire hard_chk = hard && (check_in.machine_check || check_in.channel_check);
  wire stop_req = cmd_stop || disp_wr || pd_wr || cmd_pgup || cmd_pgdn;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_r <= RUN_STOPPED;
      step_armed_r <= 1'b0;
      cmp_hit_r <= 1'b0;
      stop_addr_r <= 24'h000000;
      stop_half_r <= 16'h0000;
    end else begin
      case (run_r)
        RUN_GO: begin
          if (hard_chk) begin
            run_r <= RUN_HALTED_ON_ERROR_INDICATOR;
          end else if (stop_req) begin
            run_r <= RUN_STOPPED;
          end else if (match) begin
            cmp_hit_r <= 1'b1;
          end
          if (insn_in.boundary && (cmp_hit_r || step_armed_r) && !hard_chk) begin
            run_r <= RUN_STOPPED;
            step_armed_r <= 1'b0;
            stop_addr_r <= insn_in.next_addr;
            stop_half_r <= insn_in.next_half;
          end
        end
        RUN_STOPPED: begin
          if (hard_chk) begin
            run_r <= RUN_HALTED_ON_ERROR_INDICATOR;
          end else if (cmd_start || (ctl_wr && hwdata[`CTL_CMP_ARM])) begin
            run_r <= RUN_GO;
            cmp_hit_r <= 1'b0;
            step_armed_r <= step;
          end
        end
        RUN_HALTED_ON_ERROR_INDICATOR: run_r <= RUN_HALTED_ON_ERROR_INDICATOR;
        default: run_r <= RUN_STOPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Display paging and page description
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      disp_addr_r <= 24'h000000;
      page_desc_r <= 16'h0000;
    end else begin
      if (disp_wr) begin
        disp_addr_r <= hwdata[23:0];
      end else if (cmd_pgup) begin
        disp_addr_r <= disp_addr_r + `PAGE_BYTES;
      end else if (cmd_pgdn) begin
        disp_addr_r <= disp_addr_r - `PAGE_BYTES;
      end
      if (pd_wr) begin
        page_desc_r <= (page_desc_r & ~`PD_ALTER_MASK) | (hwdata[15:0] & `PD_ALTER_MASK);
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks, timer, clock-set window
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mc_interrupt <= 1'b0;
      mc_logout <= 1'b0;
    end else begin
      mc_interrupt <= !hard && check_in.machine_check && check_in.mc_enabled;
      mc_logout <= !hard && check_in.machine_check && check_in.mc_enabled;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tod_open_r <= 1'b0;
      tod_cnt_r <= 32'h00000000;
    end else if (cmd_tod) begin
      tod_open_r <= 1'b1;
      tod_cnt_r <= TOD_CYCLES - 1;
    end else if (tod_open_r) begin
      if (tod_cnt_r == 32'h00000000) begin
        tod_open_r <= 1'b0;
      end else begin
        tod_cnt_r <= tod_cnt_r - 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status indicators
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      saved_r <= 1'b0;
      loading_r <= 1'b0;
      load_fail_r <= 1'b0;
    end else begin
      if (save_done) begin
        saved_r <= 1'b1;
      end else if (save_abort || (cmd_wr && hwdata[`CMD_SAVE_START])) begin
        saved_r <= 1'b0;
      end
      if (cmd_ipl) begin
        loading_r <= 1'b1;
        load_fail_r <= 1'b0;
      end else if (ipl_done || ipl_failed) begin
        loading_r <= 1'b0;
        load_fail_r <= ipl_failed;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ind_r <= ST_MANUAL;
    end else if (run_r == RUN_HALTED_ON_ERROR_INDICATOR) begin
      ind_r <= ST_HALTED_ON_ERROR_INDICATOR;
    end else if (load_fail_r) begin
      ind_r <= ST_LOAD_FAIL;
    end else if (step || arm || hard || ctl_r[`CTL_INLINE_TEST]) begin
      ind_r <= ST_TEST;
    end else if (run_r == RUN_STOPPED) begin
      ind_r <= ST_MANUAL;
    end else begin
      ind_r <= ST_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      proc_run <= 1'b0;
      timer_enable <= 1'b0;
      tod_set_allowed <= 1'b0;
      single_step_mode <= 1'b0;
    end else begin
      proc_run <= (run_r == RUN_GO);
      timer_enable <= ctl_r[`CTL_TIMER_ON];
      tod_set_allowed <= tod_open_r;
      single_step_mode <= step;
    end
  end

endmodule
`default_nettype wire

// *** sim/opctl_props.sv ***
`default_nettype none
module opctl_props
  import opctl_pkg::*;
#(
  parameter int unsigned TOD_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Processor
  input wire insn_t insn_in,
  input wire check_t check_in,
  input wire logic proc_run,
  input wire logic timer_enable,
  input wire logic mc_interrupt,
  input wire logic tod_set_allowed,
  input wire logic single_step_mode
);
  logic wr_r;
  logic st_r;
  logic [31:0] tod_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_r <= 1'b0;
      st_r <= 1'b0;
      tod_r <= 32'h0;
    end else begin
      wr_r <= hsel && hready && htrans[1] && hwrite;
      st_r <= hsel && hready && htrans[1] && !hwrite && haddr[11:0] == 12'h00c;
      tod_r <= tod_set_allowed ? tod_r + 32'h1 : 32'h0;
    end
  end
  mc_cause_a: assert property (mc_interrupt |-> $past(check_in.machine_check && check_in.mc_enabled))
    else $error("interrupt without check");
  step_stop_a: assert property (single_step_mode && proc_run && insn_in.boundary |-> ##2 !proc_run)
    else $error("step did not stop");
  run_cause_a: assert property ($rose(proc_run) |-> $past(wr_r, 2))
    else $error("run without write");
  timer_cause_a: assert property ($changed(timer_enable) |-> $past(wr_r, 2))
    else $error("timer changed alone");
  tod_lapse_a: assert property (tod_r <= TOD_CYCLES + 1)
    else $error("clock set stays open");
  tod_full_a: assert property ($fell(tod_set_allowed) |-> tod_r >= TOD_CYCLES - 1)
    else $error("clock set closed early");
  ind_range_a: assert property (st_r |-> hrdata[12:10] <= 3'h4 && hrdata[7] == $past(timer_enable))
    else $error("bad indicator");
  tod_pair_a: assert property (st_r |-> hrdata[5] != hrdata[6])
    else $error("clock set flags agree");
endmodule
bind opctl opctl_props #(.TOD_CYCLES(TOD_CYCLES)) opctl_props_i (.clk_sys, .rstn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .insn_in, .check_in, .proc_run, .timer_enable, .mc_interrupt, .tod_set_allowed,
  .single_step_mode);
`default_nettype wire

// *** sim/proc_model.sv ***
`default_nettype none
module proc_model
  import opctl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Run control
  input wire logic proc_run,
  // Activity
  output var access_t access_out,
  output var insn_t insn_out
);
  logic [23:0] pc_r;
  logic [23:0] junk;
  logic ph_r;
  logic tgl_r;
  // Access on even phase, instruction end on odd phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc_r <= 24'h0;
      ph_r <= 1'b0;
      tgl_r <= 1'b0;
    end else begin
      tgl_r <= ~tgl_r;
      ph_r <= proc_run && !ph_r;
      pc_r <= !proc_run ? 24'h0 : (ph_r ? pc_r + 24'h4 : pc_r);
    end
  end
  always_comb begin
    junk = pc_r ^ {24{tgl_r}};
    access_out.valid = proc_run && !ph_r;
    access_out.addr = access_out.valid ? pc_r : junk;
    access_out.is_ifetch = pc_r[3:2] == 2'h0 || pc_r[3:2] == 2'h3;
    access_out.is_store = pc_r[3:2] == 2'h1;
    access_out.is_io = pc_r[3:2] == 2'h2;
    insn_out.boundary = proc_run && ph_r;
    insn_out.next_addr = insn_out.boundary ? pc_r + 24'h4 : junk;
    insn_out.next_half = ~insn_out.next_addr[15:0];
  end
endmodule
`default_nettype wire

// *** sim/test_opctl.sv ***
`include "opctl_defines.svh"
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", n, e, g); end end
module test_opctl
  import opctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, hsel = 0, hwrite = 0, ipl_done = 0, save_done = 0, ipl_failed = 0, save_abort = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, proc_run, timer_enable, mc_interrupt, mc_logout, tod_set_allowed, single_step_mode;
  access_t access_in;
  insn_t insn_in;
  check_t check_in = '0;
  int n_fail = 0, tests_run = 0, k;
  opctl #(.TOD_CYCLES(20)) opctl_i (.clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .access_in, .insn_in, .check_in, .ipl_done,
    .ipl_failed, .save_done, .save_abort, .proc_run, .timer_enable, .mc_interrupt, .mc_logout,
    .tod_set_allowed, .single_step_mode);
  proc_model proc_model_i (.clk_sys, .rstn, .proc_run, .access_out(access_in), .insn_out(insn_in));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    rdy();
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic wait_stop();
    int n;
    n = 0;
    while (proc_run !== 1'b0 && n < 600) begin
      @(posedge clk_sys);
      n++;
    end
    if (proc_run !== 1'b0) begin
      n_fail++;
      stop_test();
    end
  endtask
  initial begin
    cyc(2);
    rstn <= 1'b1;
    xfer(0, `OFF_STATUS, 0); `CHK("status", 14'h0421, {hresp, q[12:0]})
    xfer(1, `OFF_CONTROL, 32'h10); cyc(1);
    xfer(0, `OFF_STATUS, 0); `CHK("timer", 2'b11, {q[7], timer_enable})
    xfer(1, `OFF_CONTROL, 32'h0);
    xfer(1, `OFF_COMMAND, 32'h10); xfer(0, `OFF_STATUS, 0); `CHK("tod", 3'b110, {tod_set_allowed, q[6:5]})
    cyc(25); xfer(0, `OFF_STATUS, 0); `CHK("tod lapse", 3'b001, {tod_set_allowed, q[6:5]})
    xfer(1, `OFF_COMMAND, 32'h1); cyc(3); `CHK("run", 1'b1, proc_run)
    xfer(1, `OFF_DISP_ADDR, 32'h100); cyc(2); `CHK("display stop", 1'b0, proc_run)
    xfer(1, `OFF_COMMAND, 32'h4); xfer(0, `OFF_DISP_ADDR, 0); `CHK("page up", 32'h140, q)
    xfer(1, `OFF_COMMAND, 32'h8); xfer(1, `OFF_COMMAND, 32'h8);
    xfer(0, `OFF_DISP_ADDR, 0); `CHK("page down", 32'hc0, q)
    xfer(1, `OFF_COMMAND, 32'h1); xfer(1, `OFF_PAGE_DESC, 32'hffff);
    xfer(0, `OFF_PAGE_DESC, 0); `CHK("page desc", 32'h7, q)
    `CHK("alter stop", 1'b0, proc_run)
    for (k = 0; k < 4; k++) begin
      xfer(1, `OFF_CMP_ADDR, 32'h120 + 4 * k);
      xfer(1, `OFF_CONTROL, {29'h0, 2'(k + 1), 1'b1}); cyc(1);
      xfer(0, `OFF_STATUS, 0); `CHK("armed", 5'h18, {q[9], q[12:10], q[0]})
      wait_stop();
      xfer(0, `OFF_STOP_ADDR, 0); `CHK("stop addr", 32'h124 + 4 * k, q)
      xfer(0, `OFF_STOP_HALF, 0); `CHK("stop half", ~(16'h124 + 16'(4 * k)), q[15:0])
      xfer(0, `OFF_STATUS, 0); `CHK("hit", 2'b11, {q[1], q[0]})
    end
    xfer(1, `OFF_CMP_ADDR, 32'h120); xfer(1, `OFF_CONTROL, 32'h7); cyc(300);
    `CHK("class miss", 1'b1, proc_run)
    xfer(1, `OFF_COMMAND, 32'h2); xfer(1, `OFF_CONTROL, 32'h20); xfer(1, `OFF_COMMAND, 32'h1); cyc(6);
    `CHK("step", 2'b10, {single_step_mode, proc_run})
    xfer(0, `OFF_STOP_ADDR, 0); `CHK("step addr", 32'h4, q)
    xfer(1, `OFF_CONTROL, 32'h0); xfer(1, `OFF_COMMAND, 32'h20);
    ipl_failed <= 1'b1; cyc(1); ipl_failed <= 1'b0; cyc(1);
    xfer(0, `OFF_STATUS, 0); `CHK("load fail", 4'h3, {q[3], q[12:10]})
    xfer(1, `OFF_COMMAND, 32'h20);
    xfer(0, `OFF_STATUS, 0); `CHK("loading", 1'b1, q[3])
    ipl_done <= 1'b1; cyc(1); ipl_done <= 1'b0;
    xfer(0, `OFF_STATUS, 0); `CHK("loaded", 1'b0, q[3])
    save_done <= 1'b1; cyc(1); save_done <= 1'b0;
    xfer(0, `OFF_STATUS, 0); `CHK("saved", 1'b1, q[4])
    save_abort <= 1'b1; cyc(1); save_abort <= 1'b0;
    xfer(0, `OFF_STATUS, 0); `CHK("save abort", 1'b0, q[4])
    check_in <= '{1'b1, 1'b0, 1'b1}; cyc(1); check_in <= '0; cyc(1);
    `CHK("interrupt", 2'b11, {mc_interrupt, mc_logout})
    xfer(1, `OFF_CONTROL, 32'h8); cyc(1); xfer(0, `OFF_STATUS, 0); `CHK("hard", 4'hc, {q[8], q[12:10]})
    check_in <= '{1'b0, 1'b1, 1'b0}; cyc(1); check_in <= '0; cyc(1);
    xfer(0, `OFF_STATUS, 0); `CHK("halted_on_error_indicator", 3'h2, q[12:10])
    stop_test();
  end
endmodule
`default_nettype wire
